/* hw/cls_defs.svh */
// register offsets, field positions, reset values and codes of the comma latency stopwatch
`ifndef CLS_DEFS_SVH
`define CLS_DEFS_SVH

// management register offsets
`define CLS_REG_CTRL 5'h16
`define CLS_REG_STAT_HI 5'h17
`define CLS_REG_COUNT_LO 5'h18

// control register fields
`define CLS_CTRL_START_SEL 7
`define CLS_CTRL_STOP_SEL 6
`define CLS_CTRL_DIV_HI 5
`define CLS_CTRL_DIV_LO 4
`define CLS_CTRL_CLK_EN 3
`define CLS_CTRL_BYTE_CLK 2
`define CLS_CTRL_CHAN 0
`define CLS_CTRL_MASK 16'h00FD
`define CLS_CTRL_RESET 16'h0000

// status high register fields
`define CLS_STAT_ALIGN_LO 12
`define CLS_STAT_STOP_LOC_LO 10
`define CLS_STAT_START_LOC_LO 8
`define CLS_STAT_DONE 4

// comma codes (control flag set)
`define CLS_K28_1 8'h3C
`define CLS_K28_5 8'hBC
`define CLS_K28_7 8'hFC

// counter saturation value and reset value
`define CLS_COUNT_MAX 20'hFFFFF
`define CLS_COUNT_RESET 20'h00000

// serdes rate modes
`define CLS_RATE_FULL 2'h0
`define CLS_RATE_HALF 2'h1

// management frame constants
`define CLS_MDIO_PRE_LEN 6'h20
`define CLS_MDIO_OP_RD 2'h2
`define CLS_MDIO_OP_WR 2'h1
`define CLS_MDIO_HDR_LAST 6'h0C
`define CLS_MDIO_DATA_LAST 6'h0F

`endif

/* hw/cls_pkg.sv */
// types shared by the comma latency stopwatch modules
package cls_pkg;

   // stopwatch states
   typedef enum logic [1:0] {
      MEAS_ARMED = 2'b00,
      MEAS_RUN = 2'b01,
      MEAS_DONE = 2'b10
   } cls_meas_st_t;

   // management frame states
   typedef enum logic [2:0] {
      MS_PRE = 3'b000,
      MS_HDR = 3'b001,
      MS_TA = 3'b010,
      MS_RDAT = 3'b011,
      MS_WDAT = 3'b100
   } cls_mdio_st_t;

endpackage

/* hw/cls_mdio_slave.sv */
// management serial slave: frames on mdc/mdio into register strobes
`timescale 1ns/1ps
`include "cls_defs.svh"

module cls_mdio_slave
   import cls_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // management pins
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   input wire logic [3:0] port_addr,
   // register side
   output logic [4:0] reg_addr,
   output logic wr_stb,
   output logic [15:0] wr_data,
   output logic rd_stb,
   input wire logic [15:0] rd_data
);

   logic mdc_s1_q, mdc_s2_q, mdc_s3_q;
   logic mdio_s1_q, mdio_s2_q;
   logic [3:0] pa_s1_q, pa_s2_q;
   cls_mdio_st_t st_q;
   logic [5:0] cnt_q;
   logic [15:0] sh_q;
   logic hit_q, is_rd_q, rd_pend_q;

   // decode of the complete 13-bit header as the last address bit arrives
   wire mdc_rise = mdc_s2_q & ~mdc_s3_q;
   wire in_bit = mdio_s2_q;
   wire [12:0] hdr = {sh_q[11:0], in_bit};
   wire hdr_op_rd = (hdr[11:10] == `CLS_MDIO_OP_RD);
   wire hdr_op_wr = (hdr[11:10] == `CLS_MDIO_OP_WR);
   wire hdr_hit = hdr[12] & (hdr[9:6] == pa_s2_q) & (hdr_op_rd | hdr_op_wr);

   // pins come from another domain, so two flops before any use
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         mdc_s1_q <= 1'b0;
         mdc_s2_q <= 1'b0;
         mdc_s3_q <= 1'b0;
         mdio_s1_q <= 1'b1;
         mdio_s2_q <= 1'b1;
         pa_s1_q <= 4'h0;
         pa_s2_q <= 4'h0;
      end else begin
         mdc_s1_q <= mdc;
         mdc_s2_q <= mdc_s1_q;
         mdc_s3_q <= mdc_s2_q;
         mdio_s1_q <= mdio_in;
         mdio_s2_q <= mdio_s1_q;
         pa_s1_q <= port_addr;
         pa_s2_q <= pa_s1_q;
      end
   end

   // frame walker; read data is captured in the same cycle as rd_stb so a clear-on-read returns the old value
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         st_q <= MS_PRE;
         cnt_q <= 6'h00;
         sh_q <= 16'h0000;
         hit_q <= 1'b0;
         is_rd_q <= 1'b0;
         rd_pend_q <= 1'b0;
         rd_stb <= 1'b0;
         wr_stb <= 1'b0;
         wr_data <= 16'h0000;
         reg_addr <= 5'h00;
         mdio_out <= 1'b1;
         mdio_oe <= 1'b0;
      end else begin
         rd_stb <= rd_pend_q;
         rd_pend_q <= 1'b0;
         wr_stb <= 1'b0;
         if (rd_stb) begin
            sh_q <= rd_data;
         end
         if (mdc_rise) begin
            case (st_q)
               MS_PRE: begin
                  if (in_bit) begin
                     if (cnt_q != `CLS_MDIO_PRE_LEN) cnt_q <= cnt_q + 6'h01;
                  end else if (cnt_q == `CLS_MDIO_PRE_LEN) begin
                     st_q <= MS_HDR;
                     cnt_q <= 6'h00;
                  end else begin
                     cnt_q <= 6'h00;
                  end
               end
               MS_HDR: begin
                  sh_q <= {sh_q[14:0], in_bit};
                  cnt_q <= cnt_q + 6'h01;
                  if (cnt_q == `CLS_MDIO_HDR_LAST) begin
                     cnt_q <= 6'h00;
                     reg_addr <= hdr[4:0];
                     hit_q <= hdr_hit;
                     is_rd_q <= hdr_op_rd;
                     rd_pend_q <= hdr_hit & hdr_op_rd;
                     st_q <= hdr_hit ? MS_TA : MS_PRE;
                  end
               end
               MS_TA: begin
                  cnt_q <= cnt_q + 6'h01;
                  if (is_rd_q) begin
                     mdio_oe <= 1'b1;
                     mdio_out <= (cnt_q == 6'h00) ? 1'b0 : sh_q[15];
                  end
                  if (cnt_q != 6'h00) begin
                     cnt_q <= 6'h00;
                     st_q <= is_rd_q ? MS_RDAT : MS_WDAT;
                  end
               end
               MS_RDAT: begin
                  cnt_q <= cnt_q + 6'h01;
                  sh_q <= {sh_q[14:0], 1'b0};
                  mdio_out <= sh_q[14];
                  if (cnt_q == `CLS_MDIO_DATA_LAST) begin
                     mdio_oe <= 1'b0;
                     mdio_out <= 1'b1;
                     cnt_q <= 6'h00;
                     st_q <= MS_PRE;
                  end
               end
               MS_WDAT: begin
                  cnt_q <= cnt_q + 6'h01;
                  sh_q <= {sh_q[14:0], in_bit};
                  if (cnt_q == `CLS_MDIO_DATA_LAST) begin
                     wr_data <= {sh_q[14:0], in_bit};
                     wr_stb <= hit_q;
                     cnt_q <= 6'h00;
                     st_q <= MS_PRE;
                  end
               end
               default: begin
                  st_q <= MS_PRE;
                  cnt_q <= 6'h00;
               end
            endcase
         end
      end
   end

endmodule

/* hw/cls_latency_stopwatch.sv */
// comma-to-comma latency stopwatch with its management registers
// Behaviour
// R01: one control bit picks the start point, another picks the stop point.
// R02: a comma is a control character with code 3C, BC or FC.
// R03: first start comma starts counting; later start commas do not restart it.
// R04: first stop comma after counting began halts the counter.
// R05: 20-bit result: upper four bits in status high, lower sixteen in count low.
// R06: a span beyond the counter range reads as the maximum value.
// R07: one result is kept, unchanged until it is read.
// R08: the result is zero when no start comma was ever seen.
// R09: one channel measured at a time, clocked from that channel.
// R10: measurement clock is bit rate over 8, 4 or 2 by serdes rate.
// R11: a two-bit field divides the fast measurement clock by 1, 2, 4 or 8.
// R12: byte-clock option counts on the recovered byte clock, ignoring the divider.
// R13: accuracy is one measurement clock period; each halving halves resolution.
// R14: a done flag rises when the measurement finishes; software polls it.
// R15: reading the low count rearms, clears done and clears latched comma locations.
// R16: software reads the upper result bits before the lower ones.
// R17: software reads the low count to arm, then sends commas after alignment.
// R18: software keeps the divided clock no slower than the byte clock.
// R19: software scales the count by half the measurement clock period.
// R20: latched comma locations and lane alignment pointers are readable.
// R21: software uses the fast clock only at standard fronthaul rates.
// R22: stop commas are ignored before start; a stopped result stays frozen.
// R23: a channel-select field picks which channel's taps and clock are used.
`timescale 1ns/1ps
`include "cls_defs.svh"

module cls_latency_stopwatch
   import cls_pkg::*;
#(
   parameter int NCH = 2,
   parameter int NPT = 2
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // management pins
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   input wire logic [3:0] port_addr,
   // start taps, index is channel*NPT + point
   input wire logic [NCH*NPT-1:0] start_valid,
   input wire logic [NCH*NPT-1:0] start_ctrl,
   input wire logic [NCH*NPT*8-1:0] start_data,
   input wire logic [NCH*NPT*2-1:0] start_lane,
   // stop taps, same indexing
   input wire logic [NCH*NPT-1:0] stop_valid,
   input wire logic [NCH*NPT-1:0] stop_ctrl,
   input wire logic [NCH*NPT*8-1:0] stop_data,
   input wire logic [NCH*NPT*2-1:0] stop_lane,
   // per-channel clocking and alignment state
   input wire logic [NCH-1:0] hs_tick,
   input wire logic [NCH-1:0] byte_tick,
   input wire logic [NCH*2-1:0] rate_mode,
   input wire logic [NCH*4-1:0] align_ptr,
   // status
   output logic meas_done,
   output logic meas_running
);

   localparam int NTAP = NCH * NPT;

   logic [4:0] reg_addr;
   logic wr_stb, rd_stb;
   logic [15:0] wr_data;
   logic [15:0] rd_data;
   logic [15:0] ctrl_q;
   cls_meas_st_t st_q;
   logic [19:0] count_q;
   logic [1:0] start_loc_q, stop_loc_q;
   logic [5:0] ps_q;
   logic [NTAP-1:0] start_comma, stop_comma;

   // management serial slave
   cls_mdio_slave u_mdio (
      .mclk(mclk),
      .reset(reset),
      .mdc(mdc),
      .mdio_in(mdio_in),
      .mdio_out(mdio_out),
      .mdio_oe(mdio_oe),
      .port_addr(port_addr),
      .reg_addr(reg_addr),
      .wr_stb(wr_stb),
      .wr_data(wr_data),
      .rd_stb(rd_stb),
      .rd_data(rd_data)
   );

   // comma recognisers, one per tap
   genvar gi;
   generate
      for (gi = 0; gi < NTAP; gi = gi + 1) begin : g_tap
         wire [7:0] sd = start_data[gi*8 +: 8];
         wire [7:0] pd = stop_data[gi*8 +: 8];
         assign start_comma[gi] = start_valid[gi] & start_ctrl[gi] &
            ((sd == `CLS_K28_1) | (sd == `CLS_K28_5) | (sd == `CLS_K28_7)); // see R02
         assign stop_comma[gi] = stop_valid[gi] & stop_ctrl[gi] &
            ((pd == `CLS_K28_1) | (pd == `CLS_K28_5) | (pd == `CLS_K28_7)); // see R02
      end
   endgenerate

   // control fields
   wire chan = ctrl_q[`CLS_CTRL_CHAN]; // see R23
   wire start_sel = ctrl_q[`CLS_CTRL_START_SEL];
   wire stop_sel = ctrl_q[`CLS_CTRL_STOP_SEL];
   wire [1:0] div_sel = ctrl_q[`CLS_CTRL_DIV_HI:`CLS_CTRL_DIV_LO];
   wire clk_en = ctrl_q[`CLS_CTRL_CLK_EN];
   wire byte_mode = ctrl_q[`CLS_CTRL_BYTE_CLK];

   // tap selection: only the chosen channel's points are looked at
   wire [1:0] start_idx = {chan, start_sel}; // see R01
   wire [1:0] stop_idx = {chan, stop_sel}; // see R01
   wire start_hit = start_comma[start_idx]; // see R09
   wire stop_hit = stop_comma[stop_idx];
   wire [1:0] start_lane_sel = start_lane[start_idx*2 +: 2];
   wire [1:0] stop_lane_sel = stop_lane[stop_idx*2 +: 2];
   wire [3:0] align_sel = align_ptr[chan*4 +: 4]; // see R20

   // hs_tick comes every two serial bits; the rate prescale makes /8, /4 or /2
   // eighth rate would need a per-bit tick and runs at /2 here, a known limitation
   wire [1:0] rate_sel = rate_mode[chan*2 +: 2];
   wire [2:0] rate_exp = (rate_sel == `CLS_RATE_FULL) ? 3'h2 :
      (rate_sel == `CLS_RATE_HALF) ? 3'h1 : 3'h0; // see R10
   wire [2:0] tot_exp = rate_exp + {1'b0, div_sel}; // see R11
   wire [5:0] ps_limit = 6'(({26'h0, 6'h01} << tot_exp) - 32'h1);
   wire ps_wrap = hs_tick[chan] & (ps_q == ps_limit);
   wire fast_tick = ps_wrap;
   // the byte clock bypasses the divider entirely
   wire meas_tick = clk_en & (byte_mode ? byte_tick[chan] : fast_tick); // see R12 see R13

   // register decode
   wire sel_ctrl = (reg_addr == `CLS_REG_CTRL);
   wire sel_stat = (reg_addr == `CLS_REG_STAT_HI);
   wire sel_low = (reg_addr == `CLS_REG_COUNT_LO);
   wire ctrl_wr = wr_stb & sel_ctrl;
   wire low_rd = rd_stb & sel_low; // see R15
   wire is_done = (st_q == MEAS_DONE);

   // status high layout: align pointer, stop and start locations, done, count msbs
   wire [15:0] stat_word = {align_sel, stop_loc_q, start_loc_q, 3'b000, is_done,
      count_q[19:16]}; // see R05 see R14 see R20
   assign rd_data = sel_ctrl ? ctrl_q :
      sel_stat ? stat_word :
      sel_low ? count_q[15:0] : 16'h0000; // see R05

   // control register, writable fields only
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctrl_q <= `CLS_CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_q <= wr_data & `CLS_CTRL_MASK;
      end
   end

   // prescaler restarts on any control write so a new divider takes effect cleanly
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ps_q <= 6'h00;
      end else if (ctrl_wr | ps_wrap) begin
         ps_q <= 6'h00;
      end else if (hs_tick[chan]) begin
         ps_q <= ps_q + 6'h01;
      end
   end

   // stopwatch; comma events take priority over a clearing read so none is lost
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         st_q <= MEAS_ARMED;
         count_q <= `CLS_COUNT_RESET;
         start_loc_q <= 2'b00;
         stop_loc_q <= 2'b00;
      end else begin
         case (st_q)
            MEAS_ARMED: begin
               if (start_hit) begin
                  st_q <= MEAS_RUN; // see R03
                  count_q <= `CLS_COUNT_RESET;
                  start_loc_q <= start_lane_sel; // see R20
               end else if (low_rd) begin
                  count_q <= `CLS_COUNT_RESET; // see R08
                  start_loc_q <= 2'b00;
                  stop_loc_q <= 2'b00;
               end
            end
            MEAS_RUN: begin
               if (stop_hit) begin
                  st_q <= MEAS_DONE; // see R04
                  stop_loc_q <= stop_lane_sel; // see R20
               end else if (low_rd) begin
                  st_q <= MEAS_ARMED; // see R15
                  count_q <= `CLS_COUNT_RESET;
                  start_loc_q <= 2'b00;
                  stop_loc_q <= 2'b00;
               end else if (meas_tick && count_q != `CLS_COUNT_MAX) begin
                  count_q <= count_q + 20'h00001; // see R06
               end
            end
            MEAS_DONE: begin
               // result frozen; further commas are ignored until the low read
               if (low_rd) begin
                  st_q <= MEAS_ARMED; // see R07 see R15 see R22
                  count_q <= `CLS_COUNT_RESET;
                  start_loc_q <= 2'b00;
                  stop_loc_q <= 2'b00;
               end
            end
            default: begin
               st_q <= MEAS_ARMED;
               count_q <= `CLS_COUNT_RESET;
            end
         endcase
      end
   end

   // status pins mirror the state one cycle later so they come from flops
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         meas_done <= 1'b0;
         meas_running <= 1'b0;
      end else begin
         meas_done <= (st_q == MEAS_DONE); // see R14
         meas_running <= (st_q == MEAS_RUN);
      end
   end

endmodule

/* tb/cls_host_model.sv */
// management host model: clause 22 frames on mdc and mdio
`timescale 1ns/1ps
`include "cls_defs.svh"

module cls_host_model (
   // clock
   input wire logic mclk,
   // management pins
   output logic mdc,
   output logic mdio_in,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   // finished reads
   output logic rd_valid,
   output logic [15:0] rd_val
);
   logic h_oe, h_bit;

   // shared line with pull-up: a released line reads high, never the last bit
   assign mdio_in = mdio_oe ? mdio_out : (h_oe ? h_bit : 1'b1);
   initial begin
      mdc = 1'b0;
      h_oe = 1'b0;
      h_bit = 1'b1;
      rd_valid = 1'b0;
      rd_val = 16'h0000;
   end

   // one mdc period of 10 clocks, data set while low, line taken at the rise
   task automatic bit_cyc(input logic b, input logic drv, output logic s);
      mdc <= 1'b0;
      h_oe <= drv;
      h_bit <= b;
      repeat (5) @(posedge mclk);
      s = mdio_in;
      mdc <= 1'b1;
      repeat (5) @(posedge mclk);
   endtask

   // full frame; on a read the line is released through turnaround and data
   task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
      logic [13:0] hdr;
      logic [17:0] tail;
      logic [15:0] sh;
      logic s;
      hdr = {2'b01, op, pa, ra};
      tail = {2'b10, wd};
      sh = 16'h0000;
      for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) bit_cyc(hdr[i], 1'b1, s);
      for (int i = 17; i >= 0; i--) begin
         bit_cyc(tail[i], op == `CLS_MDIO_OP_WR, s);
         sh = {sh[14:0], s};
      end
      h_oe <= 1'b0;
      rd_val <= sh;
      rd_valid <= (op != `CLS_MDIO_OP_WR);
      @(posedge mclk);
      rd_valid <= 1'b0;
   endtask
endmodule

/* tb/cls_latency_stopwatch_props.sv */
// port-level assertions of the comma latency stopwatch
`timescale 1ns/1ps
`include "cls_defs.svh"

module cls_latency_stopwatch_props #(
   parameter int NCH = 2,
   parameter int NPT = 2
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // management pins
   input wire logic mdc,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   // taps
   input wire logic [NCH*NPT-1:0] start_valid,
   input wire logic [NCH*NPT-1:0] start_ctrl,
   input wire logic [NCH*NPT*8-1:0] start_data,
   input wire logic [NCH*NPT-1:0] stop_valid,
   input wire logic [NCH*NPT-1:0] stop_ctrl,
   input wire logic [NCH*NPT*8-1:0] stop_data,
   // status
   input wire logic meas_done,
   input wire logic meas_running
);
   logic st_any, sp_any, mdc_q;
   logic [3:0] quiet_q;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   // any tap carrying a comma; the checker cannot see which tap is selected
   function automatic logic hit(logic [NCH*NPT-1:0] v, logic [NCH*NPT-1:0] c, logic [NCH*NPT*8-1:0] d);
      hit = 1'b0;
      for (int i = 0; i < NCH * NPT; i++) hit |= v[i] & c[i] & (d[i*8+:8] inside {`CLS_K28_1, `CLS_K28_5, `CLS_K28_7});
   endfunction
   assign st_any = hit(start_valid, start_ctrl, start_data);
   assign sp_any = hit(stop_valid, stop_ctrl, stop_data);

   // cycles since mdc last moved, saturating: large means management is idle
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         mdc_q <= 1'b0;
         quiet_q <= 4'h0;
      end else begin
         mdc_q <= mdc;
         quiet_q <= (mdc != mdc_q) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
      end
   end

   a_reset_quiet: assert property (disable iff (1'b0) reset |-> !mdio_oe && mdio_out && !meas_done && !meas_running)
      else $error("outputs not cleared in reset");
   a_flags_excl: assert property (!(meas_done && meas_running)) else $error("done and running together");
   a_done_from_run: assert property ($rose(meas_done) |-> $past(meas_running))
      else $error("done without a run");
   a_run_cause: assert property ($rose(meas_running) |-> $past(st_any) || $past(st_any, 2) || $past(st_any, 3))
      else $error("run without start comma");
   a_done_cause: assert property ($rose(meas_done) |-> $past(sp_any) || $past(sp_any, 2) || $past(sp_any, 3))
      else $error("done without stop comma");
   a_done_kept: assert property ($fell(meas_done) |-> quiet_q < 4'hC) else $error("result dropped unread");
   a_run_kept: assert property ($fell(meas_running) && !meas_done |-> quiet_q < 4'hC)
      else $error("run aborted unread");
   a_oe_quiet: assert property ($changed(mdio_oe) |-> quiet_q < 4'hC) else $error("mdio enable moved while idle");
   a_out_quiet: assert property ($changed(mdio_out) |-> quiet_q < 4'hC) else $error("mdio out moved while idle");
   a_armed_wait: assert property ((!meas_running && !meas_done && !st_any) [*3] |=> !meas_running)
      else $error("run started by itself");
endmodule

bind cls_latency_stopwatch cls_latency_stopwatch_props #(.NCH(NCH), .NPT(NPT)) u_props (.mclk(mclk), .reset(reset),
   .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .start_valid(start_valid), .start_ctrl(start_ctrl),
   .start_data(start_data), .stop_valid(stop_valid), .stop_ctrl(stop_ctrl), .stop_data(stop_data),
   .meas_done(meas_done), .meas_running(meas_running));

/* tb/cls_latency_stopwatch_tb.sv */
// self-checking bench of the comma latency stopwatch
`timescale 1ns/1ps
`include "cls_defs.svh"

module cls_latency_stopwatch_tb;
   logic mclk, reset, mdc, mdio_in, mdio_out, mdio_oe, meas_done, meas_running, rd_valid;
   logic [3:0] port_addr, start_valid, start_ctrl, stop_valid, stop_ctrl, rate_mode;
   logic [31:0] start_data, stop_data;
   logic [7:0] start_lane, stop_lane, align_ptr;
   logic [1:0] hs_tick, byte_tick;
   logic [15:0] rd_val;
   logic [15:0] expq[$];
   logic [7:0] codes [3] = '{`CLS_K28_1, `CLS_K28_5, `CLS_K28_7};
   int err_count, n_tests, cyc;

   cls_latency_stopwatch #(.NCH(2), .NPT(2)) DUT (.mclk(mclk), .reset(reset), .mdc(mdc), .mdio_in(mdio_in),
      .mdio_out(mdio_out), .mdio_oe(mdio_oe), .port_addr(port_addr), .start_valid(start_valid),
      .start_ctrl(start_ctrl), .start_data(start_data), .start_lane(start_lane), .stop_valid(stop_valid),
      .stop_ctrl(stop_ctrl), .stop_data(stop_data), .stop_lane(stop_lane), .hs_tick(hs_tick),
      .byte_tick(byte_tick), .rate_mode(rate_mode), .align_ptr(align_ptr), .meas_done(meas_done),
      .meas_running(meas_running));
   cls_host_model u_host (.mclk(mclk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
      .rd_valid(rd_valid), .rd_val(rd_val));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic final_report;
      if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // watcher: each finished read is matched against the oldest note
   always @(posedge mclk) begin
      if (rd_valid === 1'b1) check("rdata", expq.size() > 0 ? expq.pop_front() : 16'hDEAD, rd_val);
   end

   // hang guard, a little above the expected run length
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 98000) begin
         err_count++;
         final_report();
      end
   end

   // register access; the channel bit of the phy address is random, it must not matter
   task automatic rd(input logic [4:0] ra, input logic [15:0] e);
      expq.push_back(e);
      u_host.frame(`CLS_MDIO_OP_RD, {port_addr, 1'($urandom)}, ra, 16'h0000);
   endtask
   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      u_host.frame(`CLS_MDIO_OP_WR, {port_addr, 1'($urandom)}, ra, d);
   endtask
   // the flag pins lag the state by one cycle, so let an edge pass before looking
   task automatic st(input logic [1:0] e);
      @(posedge mclk);
      #1 check("flags", {14'h0000, e}, {14'h0000, meas_done, meas_running});
   endtask

   // one character on one tap for one cycle, random bytes on the others
   task automatic tap(input bit s, input int i, input logic c, input logic [7:0] d);
      logic [31:0] b;
      b = $urandom;
      b[i*8+:8] = d;
      @(posedge mclk);
      if (s) begin
         start_valid <= 4'(1 << i);
         start_ctrl <= {3'b000, c} << i;
         start_data <= b;
      end else begin
         stop_valid <= 4'(1 << i);
         stop_ctrl <= {3'b000, c} << i;
         stop_data <= b;
      end
      @(posedge mclk);
      start_valid <= 4'h0;
      stop_valid <= 4'h0;
   endtask

   // in runs up to 1000, ticks of the measured channel alternate with ticks of the other one
   task automatic ticks(input bit hs, input int ch, input int n);
      logic [1:0] a;
      a = 2'(1 << ch);
      if (n > 1000) begin
         // long runs hold the tick steady; it is seen at exactly n edges
         @(posedge mclk);
         if (hs) hs_tick <= a; else byte_tick <= a;
         repeat (n - 1) @(posedge mclk);
      end else repeat (n) begin
         @(posedge mclk);
         if (hs) hs_tick <= a; else byte_tick <= a;
         @(posedge mclk);
         if (hs) hs_tick <= ~a; else byte_tick <= ~a;
      end
      @(posedge mclk);
      hs_tick <= 2'b00;
      byte_tick <= 2'b00;
   endtask

   // one full measurement with stray commas before, during and after it
   task automatic meas(input int ch, input int sp, input int pp, input int k, input bit bc, input int dv,
      input logic [19:0] n);
      int si, pi, rm, m;
      logic [1:0] sl, pl;
      si = ch * 2 + sp;
      pi = ch * 2 + pp;
      rm = $urandom % 4;
      m = bc ? 1 : 1 << ((rm >= 2 ? 0 : 2 - rm) + dv); // ticks per count; latency is count times half a period
      sl = 2'($urandom);
      pl = 2'($urandom);
      rate_mode <= {2{2'(rm)}}; // any of the four rate codes is used, the same on both channels
      start_lane <= {4{sl}};
      stop_lane <= {4{pl}};
      wr(`CLS_REG_CTRL, 16'(sp * 128 + pp * 64 + dv * 16 + 8 + bc * 4 + ch));
      tap(0, pi, 1'b1, codes[k]);
      tap(1, si ^ 1, 1'b1, codes[k]);
      tap(1, si ^ 2, 1'b1, codes[k]);
      tap(1, si, 1'b1, 8'h7C);
      tap(1, si, 1'b0, codes[k]);
      st(2'b00);
      tap(1, si, 1'b1, codes[k]);
      ticks(!bc, ch, int'(n / 2) * m);
      tap(1, si, 1'b1, codes[k]);
      ticks(!bc, ch, int'(n - n / 2) * m);
      tap(0, pi, 1'b1, codes[k]);
      ticks(!bc, ch, 3 * m);
      tap(1, si, 1'b1, codes[k]);
      tap(0, pi, 1'b1, codes[k]);
      st(2'b10);
      rd(`CLS_REG_STAT_HI, {align_ptr[ch*4+:4], pl, sl, 4'h1, n[19:16]});
      rd(`CLS_REG_COUNT_LO, n[15:0]);
      rd(`CLS_REG_STAT_HI, {align_ptr[ch*4+:4], 12'h000});
      st(2'b00);
   endtask

   initial begin
      void'($urandom(4));
      reset = 1'b1;
      port_addr = 4'($urandom);
      align_ptr = 8'($urandom);
      {rate_mode, start_valid, start_ctrl, stop_valid, stop_ctrl} = 20'h00000;
      {start_data, stop_data, start_lane, stop_lane, hs_tick, byte_tick} = 84'h0;
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      repeat (4) @(posedge mclk);
      rd(`CLS_REG_CTRL, `CLS_CTRL_RESET);
      rd(`CLS_REG_COUNT_LO, 16'h0000);
      rd(5'h05, 16'h0000);
      wr(`CLS_REG_STAT_HI, 16'hFFFF);
      rd(`CLS_REG_STAT_HI, {align_ptr[3:0], 12'h000});
      wr(`CLS_REG_CTRL, 16'hFFFF);
      rd(`CLS_REG_CTRL, `CLS_CTRL_MASK);
      // a foreign port address gets no answer, so the pull-up reads as ones
      expq.push_back(16'hFFFF);
      u_host.frame(`CLS_MDIO_OP_RD, {~port_addr, 1'b0}, `CLS_REG_CTRL, 16'h0000);
      meas(0, 0, 0, 0, 1'b0, 0, 20'h00005);
      meas(1, 1, 0, 1, 1'b0, 3, 20'h00003);
      meas(0, 1, 1, 2, 1'b0, 1, 20'h00004);
      meas(1, 0, 1, 1, 1'b1, 2, 20'h00007);
      meas(0, 0, 1, 0, 1'b1, 0, 20'h10001);
      // a low count read in mid-run rearms, the later stop comma is ignored
      wr(`CLS_REG_CTRL, 16'h000C);
      tap(1, 0, 1'b1, `CLS_K28_5);
      ticks(1'b0, 0, 2);
      rd(`CLS_REG_COUNT_LO, 16'h0002);
      tap(0, 0, 1'b1, `CLS_K28_5);
      st(2'b00);
      rd(`CLS_REG_COUNT_LO, 16'h0000);
      repeat (3) @(posedge mclk);
      final_report();
   end
endmodule
